// ==== shared/swb_params.svh ====
`ifndef SWB_PARAMS_SVH
`define SWB_PARAMS_SVH

// burst field of mode register zero
`define SWB_BURST_FIXED8   2'h0
`define SWB_BURST_PERCMD   2'h1
`define SWB_BURST_FIXED4   2'h2
`define SWB_BURST_RSVD     2'h3

// device organization
`define SWB_ORG_X4         2'h0
`define SWB_ORG_X8         2'h1
`define SWB_ORG_X16        2'h2
`define SWB_ORG_RSVD       2'h3

// burst lengths in beats
`define SWB_BEATS_FULL     4'h8
`define SWB_BEATS_CHOP     4'h4

// timing figures in command clock cycles
`define SWB_LOWEST_COL_LAT 5'h09
`define SWB_GAP_FORBIDDEN  8'h05

// widths and depths
`define SWB_DQ_W           16
`define SWB_LANES          2
`define SWB_BANK_W         3
`define SWB_COL_W          10
`define SWB_LAT_W          5
`define SWB_CNT_W          8
`define SWB_QDEPTH         8
`define SWB_FIFO_DEPTH     32

`endif

// ==== shared/swb_pkg.sv ====
`default_nettype none
`include "swb_params.svh"

package swb_pkg;

	typedef enum logic [1:0] {
		SWB_FIXED8 = `SWB_BURST_FIXED8,
		SWB_PERCMD = `SWB_BURST_PERCMD,
		SWB_FIXED4 = `SWB_BURST_FIXED4,
		SWB_RSVD   = `SWB_BURST_RSVD
	} swb_burst_field_t;

	typedef enum logic [1:0] {
		SWB_X4     = `SWB_ORG_X4,
		SWB_X8     = `SWB_ORG_X8,
		SWB_X16    = `SWB_ORG_X16,
		SWB_XRSVD  = `SWB_ORG_RSVD
	} swb_org_t;

	typedef enum logic [0:0] {
		SWB_IDLE  = 1'b0,
		SWB_BURST = 1'b1
	} swb_state_t;

endpackage

`default_nettype wire

// ==== rtl/swb_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none

module swb_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0]      wr_ptr_ff;
	logic [AW:0]      rd_ptr_ff;
	logic             push;
	logic             pop;

	// extra pointer bit tells full from empty
	assign in_ready  = (wr_ptr_ff[AW] == rd_ptr_ff[AW]) || (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]);
	assign out_valid = (wr_ptr_ff != rd_ptr_ff);
	assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_ptr_ff <= '0;
		end else if (push) begin
			wr_ptr_ff <= wr_ptr_ff + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_ptr_ff <= '0;
		end else if (pop) begin
			rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end

endmodule

`default_nettype wire

// ==== rtl/swb_write_burst.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "swb_params.svh"

module swb_write_burst (
	input  wire logic                      CLK,
	input  wire logic                      RESETN,
	// link pins, asynchronous to CLK
	input  wire logic                      CK,
	input  wire logic                      CMD_WRITE_N,
	input  wire logic                      CMD_ACT_N,
	input  wire logic                      CMD_PRE_N,
	input  wire logic [`SWB_BANK_W-1:0]    BANK_ADDR,
	input  wire logic [`SWB_COL_W-1:0]     COL_ADDR,
	input  wire logic                      CHOP_SELECT_ADDR_BIT,
	input  wire logic                      AUTO_CLOSE_ADDR_BIT,
	input  wire logic [`SWB_DQ_W-1:0]      DQ,
	input  wire logic [`SWB_LANES-1:0]     BYTE_MASK_PIN_N,
	// configuration
	input  wire logic [1:0]                BURST_FIELD,
	input  wire logic [1:0]                ORGANIZATION,
	input  wire logic [`SWB_LAT_W-1:0]     POSTED_DELAY,
	input  wire logic [`SWB_LAT_W-1:0]     COLUMN_STORE_LATENCY,
	input  wire logic                      PREAMBLE_TWO_CYCLE,
	input  wire logic                      MASK_ENABLE,
	input  wire logic                      BUS_INVERSION_ENABLE,
	input  wire logic                      STORE_CRC_ENABLE,
	input  wire logic                      ERR_CLEAR,
	// array side
	output logic                           STORE_VALID,
	input  wire logic                      STORE_READY,
	output logic [`SWB_DQ_W-1:0]           STORE_DATA,
	output logic [`SWB_LANES-1:0]          STORE_LANE_EN,
	output logic [`SWB_BANK_W-1:0]         STORE_BANK,
	output logic [`SWB_COL_W-1:0]          STORE_COL,
	output logic                           STORE_LAST,
	output logic                           STORE_AUTOCLOSE,
	// status
	output logic [(1<<`SWB_BANK_W)-1:0]    BANK_OPEN,
	output logic [`SWB_LAT_W:0]            STORE_LATENCY,
	output logic                           MASK_ACTIVE,
	output logic                           CRC_PERSISTENT,
	output logic                           CRC_NONPERSISTENT,
	output logic                           BURST_BUSY,
	output logic                           RECOVERY_REF,
	output logic                           CFG_ERR,
	output logic                           SPACING_ERR,
	output logic                           OVERFLOW
);

	//==========================================================
	// pin synchronisers and command clock edges
	localparam int PW  = 1 + 3 + `SWB_BANK_W + `SWB_COL_W + 2 + `SWB_DQ_W + `SWB_LANES;
	localparam int FW  = `SWB_DQ_W + `SWB_LANES + `SWB_BANK_W + `SWB_COL_W + 2;
	localparam int QD  = `SWB_QDEPTH;
	localparam int QAW = $clog2(QD);

	logic [PW-1:0]            pin_meta_ff;
	logic [PW-1:0]            pin_sync_ff;
	logic                     ck_prev_ff;
	logic                     ck_s;
	logic                     wr_n_s;
	logic                     act_n_s;
	logic                     pre_n_s;
	logic [`SWB_BANK_W-1:0]   bank_s;
	logic [`SWB_COL_W-1:0]    col_s;
	logic                     chop_s;
	logic                     close_s;
	logic [`SWB_DQ_W-1:0]     dq_s;
	logic [`SWB_LANES-1:0]    mask_n_s;
	logic                     ck_rise;
	logic                     ck_fall;

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			pin_meta_ff <= '1;
			pin_sync_ff <= '1;
		end else begin
			pin_meta_ff <= {CK, CMD_WRITE_N, CMD_ACT_N, CMD_PRE_N, BANK_ADDR, COL_ADDR,
				CHOP_SELECT_ADDR_BIT, AUTO_CLOSE_ADDR_BIT, DQ, BYTE_MASK_PIN_N};
			pin_sync_ff <= pin_meta_ff;
		end
	end

	assign {ck_s, wr_n_s, act_n_s, pre_n_s, bank_s, col_s, chop_s, close_s, dq_s, mask_n_s}
		= pin_sync_ff;

	// reset to high so a clock parked high gives no false edge
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ck_prev_ff <= 1'b1;
		end else begin
			ck_prev_ff <= ck_s;
		end
	end

	assign ck_rise = ck_s & ~ck_prev_ff;
	assign ck_fall = ~ck_s & ck_prev_ff;

	//==========================================================
	// configuration decode
	logic [`SWB_LAT_W:0]  st_lat;
	logic                 mask_on;
	logic                 cmd_chop;

	assign st_lat = {1'b0, POSTED_DELAY} + {1'b0, COLUMN_STORE_LATENCY};

	// masking on any part but x4, on writes, and never with inversion
	assign mask_on = MASK_ENABLE & ~BUS_INVERSION_ENABLE
		& (swb_pkg::swb_org_t'(ORGANIZATION) != swb_pkg::SWB_X4);

	always_comb begin
		cmd_chop = 1'b0;
		unique case (swb_pkg::swb_burst_field_t'(BURST_FIELD))
			swb_pkg::SWB_FIXED8: cmd_chop = 1'b0;
			swb_pkg::SWB_FIXED4: cmd_chop = 1'b1;
			swb_pkg::SWB_PERCMD: cmd_chop = ~chop_s;
			swb_pkg::SWB_RSVD:   cmd_chop = 1'b0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			STORE_LATENCY     <= '0;
			MASK_ACTIVE       <= 1'b0;
			CRC_PERSISTENT    <= 1'b0;
			CRC_NONPERSISTENT <= 1'b0;
			CFG_ERR           <= 1'b0;
		end else begin
			STORE_LATENCY     <= st_lat;
			MASK_ACTIVE       <= mask_on;
			CRC_PERSISTENT    <= STORE_CRC_ENABLE & MASK_ENABLE;
			CRC_NONPERSISTENT <= STORE_CRC_ENABLE & ~MASK_ENABLE;
			// latency at the lowest setting cannot host a two-cycle preamble
			CFG_ERR           <= PREAMBLE_TWO_CYCLE
				& (COLUMN_STORE_LATENCY <= `SWB_LOWEST_COL_LAT);
		end
	end

	//==========================================================
	// command clock counter and pending write queue
	logic [`SWB_CNT_W-1:0]    ck_count_ff;
	logic [`SWB_CNT_W-1:0]    last_wr_ff;
	logic                     have_wr_ff;
	logic                     q_chop_ff  [QD];
	logic                     q_close_ff [QD];
	logic [`SWB_BANK_W-1:0]   q_bank_ff  [QD];
	logic [`SWB_COL_W-1:0]    q_col_ff   [QD];
	logic [`SWB_CNT_W-1:0]    q_due_ff   [QD];
	logic [QAW-1:0]           q_wr_ff;
	logic [QAW-1:0]           q_rd_ff;
	logic [QAW:0]             q_cnt_ff;
	logic                     wr_cmd;
	logic                     q_push;
	logic                     q_pop;
	logic                     q_lost;

	assign wr_cmd = ck_rise & ~wr_n_s;
	assign q_push = wr_cmd & (q_cnt_ff != QD[QAW:0]);
	assign q_lost = wr_cmd & (q_cnt_ff == QD[QAW:0]);
	// first beat is taken at the rise that lands store latency after the command
	assign q_pop  = ck_rise & (q_cnt_ff != '0) & (q_due_ff[q_rd_ff] == ck_count_ff);

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ck_count_ff <= '0;
		end else if (ck_rise) begin
			ck_count_ff <= ck_count_ff + 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (q_push) begin
			q_chop_ff[q_wr_ff]  <= cmd_chop;
			q_close_ff[q_wr_ff] <= close_s;
			q_bank_ff[q_wr_ff]  <= bank_s;
			q_col_ff[q_wr_ff]   <= col_s;
			q_due_ff[q_wr_ff]   <= ck_count_ff + {{(`SWB_CNT_W-`SWB_LAT_W-1){1'b0}}, st_lat};
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			q_wr_ff  <= '0;
			q_rd_ff  <= '0;
			q_cnt_ff <= '0;
		end else begin
			if (q_push) begin
				q_wr_ff <= q_wr_ff + 1'b1;
			end
			if (q_pop) begin
				q_rd_ff <= q_rd_ff + 1'b1;
			end
			q_cnt_ff <= q_cnt_ff + {{QAW{1'b0}}, q_push} - {{QAW{1'b0}}, q_pop};
		end
	end

	// a forbidden command gap is flagged, the write itself still proceeds
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			last_wr_ff  <= '0;
			have_wr_ff  <= 1'b0;
			SPACING_ERR <= 1'b0;
		end else begin
			SPACING_ERR <= wr_cmd & have_wr_ff & PREAMBLE_TWO_CYCLE
				& ((ck_count_ff - last_wr_ff) == `SWB_GAP_FORBIDDEN);
			if (wr_cmd) begin
				last_wr_ff <= ck_count_ff;
				have_wr_ff <= 1'b1;
			end
		end
	end

	//==========================================================
	// burst engine: one beat per command clock edge
	swb_pkg::swb_state_t      state_ff;
	logic [3:0]               beat_ff;
	logic                     b_chop_ff;
	logic                     b_close_ff;
	logic [`SWB_BANK_W-1:0]   b_bank_ff;
	logic [`SWB_COL_W-1:0]    b_col_ff;
	logic                     cap_en;
	logic [3:0]               cap_idx;
	logic                     cap_chop;
	logic                     cap_close;
	logic [`SWB_BANK_W-1:0]   cap_bank;
	logic [`SWB_COL_W-1:0]    cap_col;
	logic                     cap_last;
	logic [`SWB_LANES-1:0]    lane_en;
	logic                     fifo_in_ready;

	always_comb begin
		cap_en    = 1'b0;
		cap_idx   = beat_ff;
		cap_chop  = b_chop_ff;
		cap_close = b_close_ff;
		cap_bank  = b_bank_ff;
		cap_col   = b_col_ff;
		if (q_pop) begin
			cap_en    = 1'b1;
			cap_idx   = 4'h0;
			cap_chop  = q_chop_ff[q_rd_ff];
			cap_close = q_close_ff[q_rd_ff];
			cap_bank  = q_bank_ff[q_rd_ff];
			cap_col   = q_col_ff[q_rd_ff];
		end else if ((state_ff == swb_pkg::SWB_BURST) && (ck_rise || ck_fall)) begin
			cap_en = 1'b1;
		end
	end

	// beats past the burst length are never captured
	assign cap_last = (cap_idx == ((cap_chop ? `SWB_BEATS_CHOP : `SWB_BEATS_FULL) - 4'h1));

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			state_ff <= swb_pkg::SWB_IDLE;
			beat_ff  <= '0;
		end else if (cap_en) begin
			beat_ff  <= cap_idx + 4'h1;
			state_ff <= cap_last ? swb_pkg::SWB_IDLE : swb_pkg::SWB_BURST;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			b_chop_ff  <= 1'b0;
			b_close_ff <= 1'b0;
			b_bank_ff  <= '0;
			b_col_ff   <= '0;
		end else if (q_pop) begin
			b_chop_ff  <= cap_chop;
			b_close_ff <= cap_close;
			b_bank_ff  <= cap_bank;
			b_col_ff   <= cap_col;
		end
	end

	// with masking active a lane whose mask is low keeps the stored byte; high stores it
	genvar gl;
	generate
		for (gl = 0; gl < `SWB_LANES; gl++) begin : g_lane
			assign lane_en[gl] = ~mask_on | mask_n_s[gl];
		end
	endgenerate

	//==========================================================
	// end of burst: recovery reference and automatic close
	logic                     ref_pend_ff;
	logic                     ref_close_ff;
	logic [`SWB_BANK_W-1:0]   ref_bank_ff;
	logic                     ref_fire;

	assign ref_fire = ref_pend_ff & ck_rise;

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ref_pend_ff  <= 1'b0;
			ref_close_ff <= 1'b0;
			ref_bank_ff  <= '0;
			RECOVERY_REF <= 1'b0;
		end else begin
			RECOVERY_REF <= ref_fire;
			if (cap_en && cap_last) begin
				ref_pend_ff  <= 1'b1;
				ref_close_ff <= cap_close;
				ref_bank_ff  <= cap_bank;
			end else if (ref_fire) begin
				ref_pend_ff <= 1'b0;
			end
		end
	end

	// activate opens; precharge or an auto-close burst end closes
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			BANK_OPEN <= '0;
		end else if (ck_rise) begin
			for (int b = 0; b < (1 << `SWB_BANK_W); b++) begin
				if (!act_n_s && (bank_s == b[`SWB_BANK_W-1:0])) begin
					BANK_OPEN[b] <= 1'b1;
				end else if ((!pre_n_s && (bank_s == b[`SWB_BANK_W-1:0]))
					|| (ref_pend_ff && ref_close_ff && (ref_bank_ff == b[`SWB_BANK_W-1:0]))) begin
					BANK_OPEN[b] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			BURST_BUSY <= 1'b0;
		end else begin
			BURST_BUSY <= (state_ff == swb_pkg::SWB_BURST) | (q_cnt_ff != '0) | ref_pend_ff;
		end
	end

	//==========================================================
	// beat buffer and registered array port
	logic [FW-1:0]            fifo_in;
	logic [FW-1:0]            fifo_out;
	logic                     fifo_out_valid;
	logic                     fifo_out_ready;
	logic [`SWB_COL_W-1:0]    beat_col;

	// beats walk the low column bits in order, wrapping in the eight-beat group
	assign beat_col = {cap_col[`SWB_COL_W-1:3], cap_col[2:0] + cap_idx[2:0]};
	assign fifo_in  = {dq_s, lane_en, cap_bank, beat_col, cap_last, cap_close};
	assign fifo_out_ready = ~STORE_VALID | STORE_READY;

	swb_fifo #(
		.WIDTH (FW),
		.DEPTH (`SWB_FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.resetn    (RESETN),
		.in_valid  (cap_en),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out)
	);

	// the link cannot be stalled, so a full buffer or queue is reported
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			OVERFLOW <= 1'b0;
		end else if ((cap_en && !fifo_in_ready) || q_lost) begin
			OVERFLOW <= 1'b1;
		end else if (ERR_CLEAR) begin
			OVERFLOW <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			STORE_VALID     <= 1'b0;
			STORE_DATA      <= '0;
			STORE_LANE_EN   <= '0;
			STORE_BANK      <= '0;
			STORE_COL       <= '0;
			STORE_LAST      <= 1'b0;
			STORE_AUTOCLOSE <= 1'b0;
		end else if (fifo_out_ready) begin
			STORE_VALID <= fifo_out_valid;
			if (fifo_out_valid) begin
				{STORE_DATA, STORE_LANE_EN, STORE_BANK, STORE_COL, STORE_LAST,
					STORE_AUTOCLOSE} <= fifo_out;
			end
		end
	end

endmodule

`default_nettype wire

// ==== bench/swb_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "swb_params.svh"
// ============================================================
// port checker of the write burst block
module swb_assertions (
	input wire logic                       CLK,
	input wire logic                       RESETN,
	input wire logic [1:0]                 ORGANIZATION,
	input wire logic [`SWB_LAT_W-1:0]      COLUMN_STORE_LATENCY,
	input wire logic                       PREAMBLE_TWO_CYCLE,
	input wire logic                       MASK_ENABLE,
	input wire logic                       BUS_INVERSION_ENABLE,
	input wire logic                       STORE_CRC_ENABLE,
	input wire logic                       STORE_VALID,
	input wire logic                       STORE_READY,
	input wire logic [`SWB_LANES-1:0]      STORE_LANE_EN,
	input wire logic                       STORE_LAST,
	input wire logic                       MASK_ACTIVE,
	input wire logic                       CRC_PERSISTENT,
	input wire logic                       CRC_NONPERSISTENT,
	input wire logic                       RECOVERY_REF,
	input wire logic                       CFG_ERR,
	input wire logic                       SPACING_ERR,
	input wire logic                       OVERFLOW
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	logic [2:0] beat_cnt_ff;
	// beats handed over since the last closing beat
	always_ff @(posedge CLK) begin
		if (!RESETN)
			beat_cnt_ff <= 3'h0;
		else if (STORE_VALID && STORE_READY)
			beat_cnt_ff <= STORE_LAST ? 3'h0 : beat_cnt_ff + 3'h1;
	end
	a_x4_nomask: assert property (ORGANIZATION == 2'h0 |=> !MASK_ACTIVE)
		else $error("masking active on x4");
	a_inv_nomask: assert property (BUS_INVERSION_ENABLE |=> !MASK_ACTIVE)
		else $error("masking active with inversion");
	a_lane_full: assert property (STORE_VALID && !MASK_ACTIVE |-> STORE_LANE_EN == 2'h3)
		else $error("lane dropped without masking");
	a_crc_mode: assert property (STORE_CRC_ENABLE |=>
		CRC_PERSISTENT == $past(MASK_ENABLE) && CRC_NONPERSISTENT != $past(MASK_ENABLE))
		else $error("crc mode wrong");
	a_cfg_err: assert property (PREAMBLE_TWO_CYCLE && COLUMN_STORE_LATENCY <= 5'h09 |=> CFG_ERR)
		else $error("latency error missed");
	a_ref_pulse: assert property (RECOVERY_REF |=> !RECOVERY_REF)
		else $error("recovery mark too long");
	a_space_pulse: assert property (SPACING_ERR |-> PREAMBLE_TWO_CYCLE ##1 !SPACING_ERR)
		else $error("spacing flag wrong");
	a_burst_len: assert property (STORE_VALID && STORE_READY && STORE_LAST |->
		beat_cnt_ff == 3'h3 || beat_cnt_ff == 3'h7)
		else $error("burst not four or eight beats");
	c_chop: cover property (STORE_VALID && STORE_READY && STORE_LAST && beat_cnt_ff == 3'h3);
	c_ref: cover property (RECOVERY_REF);
	c_space: cover property (SPACING_ERR);
	c_over: cover property (OVERFLOW);
endmodule
bind swb_write_burst swb_assertions u_chk (.*);
`default_nettype wire

// ==== bench/swb_ctrl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// controller stand-in driving the link pins
module swb_ctrl_model (
	output logic        CK,
	output logic        CMD_WRITE_N,
	output logic        CMD_ACT_N,
	output logic        CMD_PRE_N,
	output logic [2:0]  BANK_ADDR,
	output logic [9:0]  COL_ADDR,
	output logic        CHOP_SELECT_ADDR_BIT,
	output logic        AUTO_CLOSE_ADDR_BIT,
	output logic [15:0] DQ,
	output logic [1:0]  BYTE_MASK_PIN_N
);
	time t_ref;
	initial begin
		{CMD_WRITE_N, CMD_ACT_N, CMD_PRE_N} = 3'h7;
		{BANK_ADDR, COL_ADDR, CHOP_SELECT_ADDR_BIT, AUTO_CLOSE_ADDR_BIT, DQ, BYTE_MASK_PIN_N} = '0;
		CK = 1'h0;
		// held still until the device synchroniser is out of reset
		#1207;
		forever #200 CK = ~CK;
	end
	// kind 0 write, 1 activate, 2 precharge; once released command lines go high and address lines turn to their inverse
	task automatic cmd(input int kind, input logic [2:0] b, input logic [9:0] c, input logic chop,
		input logic ac);
		@(negedge CK);
		CMD_WRITE_N = kind != 0;
		CMD_ACT_N = kind != 1;
		CMD_PRE_N = kind != 2;
		{BANK_ADDR, COL_ADDR, AUTO_CLOSE_ADDR_BIT} = {b, c, ac};
		CHOP_SELECT_ADDR_BIT = chop;
		@(negedge CK);
		{CMD_WRITE_N, CMD_ACT_N, CMD_PRE_N} = 3'h7;
		{BANK_ADDR, COL_ADDR, CHOP_SELECT_ADDR_BIT, AUTO_CLOSE_ADDR_BIT} = ~{b, c, chop, ac};
	endtask
	// eight beats always go out, so a chopped burst has to drop the tail itself
	task automatic data(input int lat, input logic [15:0] base, input logic [1:0] m);
		repeat (lat - 1) begin
			@(posedge CK);
			@(negedge CK);
		end
		for (int k = 0; k < 8; k++) begin
			#150;
			DQ = base + 16'(k);
			BYTE_MASK_PIN_N = m;
			@(CK);
		end
		#150;
		DQ = ~DQ;
		BYTE_MASK_PIN_N = ~m;
		@(posedge CK);
		t_ref = $time;
	endtask
endmodule
`default_nettype wire

// ==== bench/tb_sdram_write_burst_control.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t got %h want %h", $time, g, e); end end
// ============================================================
// bench top
module tb_sdram_write_burst_control;
	logic        CLK, RESETN, CK, CMD_WRITE_N, CMD_ACT_N, CMD_PRE_N, CHOP_SELECT_ADDR_BIT;
	logic        AUTO_CLOSE_ADDR_BIT, PREAMBLE_TWO_CYCLE, MASK_ENABLE, BUS_INVERSION_ENABLE;
	logic        STORE_CRC_ENABLE, ERR_CLEAR, STORE_VALID, STORE_READY, STORE_LAST;
	logic        STORE_AUTOCLOSE, MASK_ACTIVE, CRC_PERSISTENT, CRC_NONPERSISTENT, BURST_BUSY;
	logic        RECOVERY_REF, CFG_ERR, SPACING_ERR, OVERFLOW, sp_seen;
	logic [1:0]  BYTE_MASK_PIN_N, BURST_FIELD, ORGANIZATION, STORE_LANE_EN;
	logic [2:0]  BANK_ADDR, STORE_BANK;
	logic [4:0]  POSTED_DELAY, COLUMN_STORE_LATENCY;
	logic [5:0]  STORE_LATENCY;
	logic [7:0]  BANK_OPEN;
	logic [9:0]  COL_ADDR, STORE_COL;
	logic [15:0] DQ, STORE_DATA;
	logic [32:0] q[$];
	time         t_pulse;
	int          num_errors, tests_run;
	swb_write_burst DUT (.*);
	swb_ctrl_model m_ctl (.*);
	always @(posedge CLK) begin
		if (STORE_VALID === 1'h1 && STORE_READY)
			q.push_back({STORE_LAST, STORE_AUTOCLOSE, STORE_LANE_EN, STORE_BANK, STORE_COL, STORE_DATA});
		if (SPACING_ERR === 1'h1)
			sp_seen = 1'h1;
		if (RECOVERY_REF === 1'h1)
			t_pulse = $time;
	end
	task automatic finish_test;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic idle;
		int n;
		for (n = 0; n < 600 && (BURST_BUSY !== 1'h0 || STORE_VALID !== 1'h0); n++)
			@(negedge CLK);
		`CHK(n < 600, 1'h1)
	endtask
	task automatic chk(input int n, input logic [2:0] b, input logic [9:0] c, input logic ac,
		input logic [1:0] ln, input logic [15:0] base);
		logic [32:0] e;
		for (int k = 0; k < n; k++) begin
			e = q.size() ? q.pop_front() : 'x;
			`CHK(e, {k == n - 1, ac, ln, b, c[9:3], 3'(c[2:0] + k), 16'(base + k)})
		end
	endtask
	task automatic wr(input int n, input logic [2:0] b, input logic [9:0] c, input logic chop,
		input logic ac, input logic [1:0] m, input logic [1:0] ln, input logic [15:0] base);
		m_ctl.cmd(0, b, c, chop, ac);
		m_ctl.data(POSTED_DELAY + COLUMN_STORE_LATENCY, base, m);
		idle();
		chk(n, b, c, ac, ln, base);
		`CHK(q.size(), 0)
	endtask
	// field per case: 00, 10, 01, 01, 11; chop bit alternates
	task automatic t_modes;
		for (int i = 0; i < 5; i++) begin
			@(negedge CLK);
			BURST_FIELD = 2'(10'h358 >> (2 * i));
			POSTED_DELAY = (i == 0) ? 5'h0A : 5'h00;
			repeat (2) @(negedge CLK);
			`CHK(STORE_LATENCY, 6'(POSTED_DELAY) + 6'h09)
			wr((i == 1 || i == 2) ? 4 : 8, 3'h7, 10'h00E, 1'(i), 1'h0, 2'h3, 2'h3,
				16'(i << 8));
		end
	endtask
	task automatic t_mask;
		for (int i = 0; i < 3; i++) begin
			@(negedge CLK);
			ORGANIZATION = (i == 0) ? 2'h2 : (i == 1) ? 2'h0 : 2'h1;
			BUS_INVERSION_ENABLE = i == 2;
			MASK_ENABLE = 1'h1;
			STORE_CRC_ENABLE = 1'h1;
			repeat (2) @(negedge CLK);
			`CHK(MASK_ACTIVE, i == 0)
			`CHK({CRC_PERSISTENT, CRC_NONPERSISTENT}, 2'h2)
			wr(8, 3'h1, 10'h3F5, 1'h0, 1'h0, 2'h1, (i == 0) ? 2'h1 : 2'h3, 16'hA5C0);
		end
		MASK_ENABLE = 1'h0;
		repeat (2) @(negedge CLK);
		`CHK({CRC_PERSISTENT, CRC_NONPERSISTENT}, 2'h1)
	endtask
	task automatic t_close;
		m_ctl.cmd(1, 3'h5, 10'h000, 1'h0, 1'h0);
		repeat (4) @(negedge CLK);
		`CHK(BANK_OPEN[5], 1'h1)
		wr(8, 3'h5, 10'h010, 1'h0, 1'h0, 2'h3, 2'h3, 16'h1200);
		`CHK(BANK_OPEN[5], 1'h1)
		// precharge waits out latency plus four plus a recovery of twelve
		repeat (13) @(posedge CK);
		m_ctl.cmd(2, 3'h5, 10'h000, 1'h0, 1'h0);
		`CHK(BANK_OPEN[5], 1'h0)
		m_ctl.cmd(1, 3'h5, 10'h000, 1'h0, 1'h0);
		`CHK(BANK_OPEN[5], 1'h1)
		wr(8, 3'h5, 10'h020, 1'h0, 1'h1, 2'h3, 2'h3, 16'h2200);
		`CHK((t_pulse - m_ctl.t_ref) inside {[50:300]}, 1'h1)
		`CHK(BANK_OPEN[5], 1'h0)
	endtask
	task automatic t_space;
		@(negedge CLK);
		PREAMBLE_TWO_CYCLE = 1'h1;
		repeat (3) @(negedge CLK);
		`CHK(CFG_ERR, 1'h1)
		COLUMN_STORE_LATENCY = 5'h0A;
		repeat (3) @(negedge CLK);
		`CHK(CFG_ERR, 1'h0)
		for (int g = 5; g < 7; g++) begin
			sp_seen = 1'h0;
			m_ctl.cmd(0, 3'h2, 10'h100, 1'h1, 1'h0);
			fork
				m_ctl.data(10, 16'h3000, 2'h3);
				begin
					repeat (g - 2) @(negedge CK);
					m_ctl.cmd(0, 3'h6, 10'h200, 1'h1, 1'h0);
					m_ctl.data(10, 16'h4000, 2'h3);
				end
			join
			idle();
			`CHK(sp_seen, g == 5)
			chk(8, 3'h2, 10'h100, 1'h0, 2'h3, 16'h3000);
			chk(8, 3'h6, 10'h200, 1'h0, 2'h3, 16'h4000);
		end
		PREAMBLE_TWO_CYCLE = 1'h0;
		COLUMN_STORE_LATENCY = 5'h09;
	endtask
	// array stalls while five bursts arrive: more beats than the buffer holds
	task automatic t_over;
		@(negedge CLK);
		STORE_READY = 1'h0;
		for (int i = 0; i < 5; i++) begin
			m_ctl.cmd(0, 3'h0, 10'h000, 1'h1, 1'h0);
			m_ctl.data(9, 16'h5000 + 16'(i << 4), 2'h3);
		end
		repeat (4) @(negedge CLK);
		`CHK(OVERFLOW, 1'h1)
		ERR_CLEAR = 1'h1;
		@(negedge CLK);
		ERR_CLEAR = 1'h0;
		repeat (2) @(negedge CLK);
		`CHK(OVERFLOW, 1'h0)
		STORE_READY = 1'h1;
		idle();
		chk(8, 3'h0, 10'h000, 1'h0, 2'h3, 16'h5000);
		q.delete();
	endtask
	initial begin
		CLK = 1'h0;
		forever #25 CLK = ~CLK;
	end
	initial begin
		#3000000;
		num_errors++;
		finish_test();
	end
	initial begin
		{RESETN, BURST_FIELD, POSTED_DELAY, PREAMBLE_TWO_CYCLE, MASK_ENABLE} = '0;
		{BUS_INVERSION_ENABLE, STORE_CRC_ENABLE, ERR_CLEAR, sp_seen} = '0;
		ORGANIZATION = 2'h2;
		COLUMN_STORE_LATENCY = 5'h09;
		STORE_READY = 1'h1;
		t_pulse = 0;
		num_errors = 0;
		tests_run = 0;
		repeat (16) @(negedge CLK);
		RESETN = 1'h1;
		t_modes();
		t_mask();
		t_close();
		t_space();
		t_over();
		finish_test();
	end
endmodule
`default_nettype wire
